/* File: fcd_pkg.sv */
// Shared constants, opcodes and types for the serial flash command decoder
package fcd_pkg;

    // ****************************************
    // Widths and counts
    // ****************************************
    localparam int          OPC_W       = 8;
    localparam int          ADDR_W      = 24;
    localparam int          CNT_W       = 6;
    localparam int          SR_W        = 8;
    localparam logic [5:0]  CNT_ZERO    = 6'h00;
    localparam logic [5:0]  CNT_OPC     = 6'h08;
    localparam logic [5:0]  CNT_SRW     = 6'h10;
    localparam logic [5:0]  CNT_ADDR    = 6'h20;
    localparam logic [5:0]  CNT_PROG    = 6'h28;
    localparam logic [5:0]  CNT_WRAP    = 6'h2f;
    localparam logic [2:0]  BYTE_LAST   = 3'h7;
    localparam logic [7:0]  ID_DEFAULT  = 8'h5a;   // Arbitrary identifier value
    localparam logic [2:0]  SYNC_RST    = 3'h1;    // Chip select idles high

    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0]  OPC_SET_WL         = 8'h06;
    localparam logic [7:0]  OPC_CLR_WL         = 8'h04;
    localparam logic [7:0]  OPC_STATUS_WR      = 8'h01;
    localparam logic [7:0]  OPC_HALF_BLK_ERASE = 8'h52;
    localparam logic [7:0]  OPC_BLK_ERASE      = 8'hd8;
    localparam logic [7:0]  OPC_SECT_ERASE     = 8'h20;
    localparam logic [7:0]  OPC_CHIP_ERASE_A   = 8'h60;
    localparam logic [7:0]  OPC_CHIP_ERASE_B   = 8'hc7;
    localparam logic [7:0]  OPC_PAGE_PROG      = 8'h02;
    localparam logic [7:0]  OPC_QUAD_PROG      = 8'h38;
    localparam logic [7:0]  OPC_CONT_PROG      = 8'had;
    localparam logic [7:0]  OPC_SLEEP          = 8'hb9;
    localparam logic [7:0]  OPC_WAKE_ID        = 8'hab;
    localparam logic [7:0]  OPC_OTP_ENTER      = 8'hb1;
    localparam logic [7:0]  OPC_OTP_EXIT       = 8'hc1;
    localparam logic [7:0]  OPC_GANG_LOCK      = 8'h7e;
    localparam logic [7:0]  OPC_GANG_UNLOCK    = 8'h98;
    localparam logic [7:0]  OPC_ONE_LOCK       = 8'h36;
    localparam logic [7:0]  OPC_ONE_UNLOCK     = 8'h39;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        FCD_OP_NONE, FCD_OP_HALF_BLK_ERASE, FCD_OP_BLK_ERASE, FCD_OP_SECT_ERASE,
        FCD_OP_CHIP_ERASE, FCD_OP_PAGE_PROG, FCD_OP_QUAD_PROG, FCD_OP_CONT_PROG,
        FCD_OP_STATUS_WR, FCD_OP_ONE_LOCK, FCD_OP_ONE_UNLOCK
    } fcd_op_t;

    typedef enum logic [2:0] {
        FCD_LEN_BAD, FCD_LEN_OPC, FCD_LEN_SRW, FCD_LEN_ADDR, FCD_LEN_PROG
    } fcd_len_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_OPC    = 5'b00010,
        ST_ARG    = 5'b00100,
        ST_IDOUT  = 5'b01000,
        ST_IGNORE = 5'b10000
    } fcd_state_t;

    typedef struct packed {
        fcd_op_t     op;
        fcd_len_t    len;
    } fcd_dec_t;

    typedef struct packed {
        fcd_op_t     op;
        logic [23:0] addr;
        logic [7:0]  data;
    } fcd_req_t;

    // ****************************************
    // Opcode table
    // ****************************************
    function automatic fcd_dec_t decode(input logic [7:0] opc);
        fcd_dec_t d;
        d = '{op: FCD_OP_NONE, len: FCD_LEN_BAD};
        unique case (opc)
            OPC_SET_WL, OPC_CLR_WL, OPC_SLEEP, OPC_OTP_ENTER, OPC_OTP_EXIT,
            OPC_GANG_LOCK, OPC_GANG_UNLOCK, OPC_WAKE_ID: d.len = FCD_LEN_OPC;
            OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: d = '{FCD_OP_CHIP_ERASE, FCD_LEN_OPC};
            OPC_HALF_BLK_ERASE: d = '{FCD_OP_HALF_BLK_ERASE, FCD_LEN_ADDR}; // R01
            OPC_BLK_ERASE:      d = '{FCD_OP_BLK_ERASE, FCD_LEN_ADDR};
            OPC_SECT_ERASE:     d = '{FCD_OP_SECT_ERASE, FCD_LEN_ADDR};
            OPC_ONE_LOCK:       d = '{FCD_OP_ONE_LOCK, FCD_LEN_ADDR};
            OPC_ONE_UNLOCK:     d = '{FCD_OP_ONE_UNLOCK, FCD_LEN_ADDR};
            OPC_STATUS_WR:      d = '{FCD_OP_STATUS_WR, FCD_LEN_SRW};
            OPC_PAGE_PROG:      d = '{FCD_OP_PAGE_PROG, FCD_LEN_PROG};
            OPC_QUAD_PROG:      d = '{FCD_OP_QUAD_PROG, FCD_LEN_PROG};
            OPC_CONT_PROG:      d = '{FCD_OP_CONT_PROG, FCD_LEN_PROG};
            default:            d.len = FCD_LEN_BAD;
        endcase
        return d;
    endfunction : decode

endpackage : fcd_pkg

/* File: fcd_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
module fcd_pin_sync
    import fcd_pkg::*;
#(
    parameter int               W       = 3,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           clk_i,
    input  wire logic           rst_n_i,
    input  wire logic           ce_i,
    input  wire logic [W-1:0]   d_i,
    output logic      [W-1:0]   q_o
);

    // ****************************************
    // Per-bit stages
    // ****************************************
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1_r;
        logic s2_r;
        logic s3_r;
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                s1_r   <= RST_VAL[i];
                s2_r   <= RST_VAL[i];
                s3_r   <= RST_VAL[i];
                q_o[i] <= RST_VAL[i];
            end else if (ce_i) begin
                s1_r <= d_i[i];
                s2_r <= s1_r;
                s3_r <= s2_r;
                // Only accept a level once two late stages agree
                if (s2_r == s3_r) begin
                    q_o[i] <= s3_r;
                end
            end
        end
    end

endmodule : fcd_pin_sync

/* File: fcd_decoder.sv */
// Serial flash command decoder with write enable latch
//
// Behaviour
// R01 - Decode half-block erase and chip erase
// R02 - Enter and leave deep power-down
// R03 - Identifier byte after 24 dummy clocks
// R04 - Enter secured OTP access mode
// R05 - Exit secured OTP access mode
// R06 - Gang lock and gang unlock whole array
// R07 - Individual protect mode starts all locked
// R08 - Host sends only defined opcodes
// R09 - Host sets latch before every modify
// R10 - Set-latch opcode alone sets the latch
// R11 - Clear-latch opcode alone clears the latch
// R12 - Finished program/erase/status write clears latch
// R13 - Power-up and lock commands clear latch
// R14 - Refuse modify commands while latch clear
// R15 - Protected target ignored, latch cleared
// R16 - Latch reported as status bit one
// R17 - Unknown opcode ignored until deselect
module fcd_decoder
    import fcd_pkg::*;
#(
    parameter logic [7:0]       ID_CODE = ID_DEFAULT
) (
    input  wire logic           mclk_i,
    input  wire logic           rst_n_i,
    input  wire logic           ce_i,
    input  wire logic           cs_n_i,
    input  wire logic           sclk_i,
    input  wire logic           si_i,
    input  wire logic           busy_i,
    input  wire logic           op_done_i,
    input  wire logic           protect_hit_i,
    input  wire logic           indiv_mode_i,
    input  wire logic [5:0]     sr_hi_i,
    output logic                so_o,
    output logic                so_oe_o,
    output logic                write_enable_latch_o,
    output logic                deep_sleep_o,
    output logic                otp_mode_o,
    output logic                all_locked_o,
    output logic                req_valid_o,
    output fcd_req_t            req_o,
    output logic [SR_W-1:0]     status_o
);

    // ****************************************
    // Reset release and pin capture
    // ****************************************
    logic               rst_ff_r;
    logic               rst_n_r;
    logic [2:0]         pins_s;
    logic               cs_act_q_r;
    logic               sclk_q_r;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_ff_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_ff_r <= 1'b1;
            rst_n_r  <= rst_ff_r;
        end
    end
    fcd_pin_sync #(
        .W       (3),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_r),
        .ce_i    (ce_i),
        .d_i     ({si_i, sclk_i, cs_n_i}),
        .q_o     (pins_s)
    );
    wire cs_act    = !pins_s[0];
    wire sclk_s    = pins_s[1];
    wire si_s      = pins_s[2];
    wire cs_fall   = cs_act && !cs_act_q_r;
    wire cs_rise   = !cs_act && cs_act_q_r;
    wire sclk_rise = cs_act && sclk_s && !sclk_q_r;
    wire sclk_fall = cs_act && !sclk_s && sclk_q_r;
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cs_act_q_r <= 1'b0;
            sclk_q_r   <= 1'b0;
        end else if (ce_i) begin
            cs_act_q_r <= cs_act;
            sclk_q_r   <= sclk_s;
        end
    end

    // ****************************************
    // Serial framing
    // ****************************************
    fcd_state_t         st_r;
    logic [CNT_W-1:0]   cnt_r;
    logic [7:0]         sh_r;
    logic [7:0]         opc_r;
    logic [ADDR_W-1:0]  addr_r;
    logic [7:0]         id_sh_r;
    logic               wel_r;
    logic               sleep_r;
    wire  [7:0]         byte_in = {sh_r[6:0], si_s};
    wire  fcd_dec_t     dec_in  = decode(byte_in);
    wire  fcd_dec_t     dec     = decode(opc_r);
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r    <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
            sh_r    <= 8'h00;
            opc_r   <= 8'h00;
            addr_r  <= '0;
            id_sh_r <= 8'h00;
        end else if (ce_i) begin
            if (cs_fall) begin
                st_r  <= ST_OPC;
                cnt_r <= CNT_ZERO;
            end else if (!cs_act) begin
                st_r  <= ST_IDLE;
            end else if (sclk_rise) begin
                sh_r  <= byte_in;
                // Counter cycles one byte past the address so long bursts keep alignment
                cnt_r <= (cnt_r == CNT_WRAP) ? CNT_PROG : cnt_r + 6'h01;
                if (cnt_r < CNT_ADDR && cnt_r >= CNT_OPC) begin
                    addr_r <= {addr_r[ADDR_W-2:0], si_s};
                end
                unique case (st_r)
                    ST_OPC: begin
                        if (cnt_r == CNT_OPC - 6'h01) begin
                            opc_r <= byte_in;
                            if (dec_in.len == FCD_LEN_BAD || busy_i) begin
                                st_r <= ST_IGNORE;                          // R17
                            end else if (sleep_r && byte_in != OPC_WAKE_ID) begin
                                st_r <= ST_IGNORE;                          // R02
                            end else begin
                                st_r <= ST_ARG;
                            end
                        end
                    end
                    ST_ARG: begin
                        if (opc_r == OPC_WAKE_ID && cnt_r == CNT_ADDR - 6'h01) begin
                            st_r    <= ST_IDOUT;                            // R03
                            id_sh_r <= {ID_CODE[0], ID_CODE[7:1]};          // R03
                        end
                    end
                    ST_IDOUT, ST_IGNORE, ST_IDLE: ;
                endcase
            end else if (sclk_fall && st_r == ST_IDOUT) begin
                id_sh_r <= {id_sh_r[6:0], id_sh_r[7]};                      // R03
            end
        end
    end

    // ****************************************
    // Execution at deselect
    // ****************************************
    wire in_arg   = (st_r == ST_ARG);
    wire byte_end = (cnt_r == CNT_PROG);
    logic len_ok;
    always_comb begin
        unique case (dec.len)
            FCD_LEN_OPC:  len_ok = (cnt_r == CNT_OPC);
            FCD_LEN_SRW:  len_ok = (cnt_r == CNT_SRW);
            FCD_LEN_ADDR: len_ok = (cnt_r == CNT_ADDR);
            FCD_LEN_PROG: len_ok = byte_end;
            default:      len_ok = 1'b0;
        endcase
    end
    wire exec      = cs_rise && in_arg && len_ok;
    wire set_x     = exec && opc_r == OPC_SET_WL;                           // R10
    wire clr_x     = exec && opc_r == OPC_CLR_WL;                           // R11
    wire gang_x    = exec && (opc_r == OPC_GANG_LOCK || opc_r == OPC_GANG_UNLOCK);
    wire mod_x     = exec && dec.op != FCD_OP_NONE;
    wire lock_op   = dec.op == FCD_OP_ONE_LOCK || dec.op == FCD_OP_ONE_UNLOCK;
    wire prot_x    = mod_x && !lock_op && dec.op != FCD_OP_STATUS_WR && protect_hit_i;
    wire grant_x   = mod_x && wel_r && !prot_x;                             // R14 R15
    wire wel_clr   = clr_x || op_done_i || prot_x                           // R12 R15
                     || (wel_r && (gang_x || (mod_x && lock_op)));           // R13
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wel_r <= 1'b0;                                                  // R13
        end else if (ce_i) begin
            if (wel_clr) begin
                wel_r <= 1'b0;
            end
            // Set placed last so a clear in the same cycle loses
            if (set_x) begin
                wel_r <= 1'b1;
            end
        end
    end
    // Any complete wake opcode received while busy_i is low, with or without the identifier read, ends sleep
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sleep_r      <= 1'b0;
            otp_mode_o   <= 1'b0;
        end else if (ce_i) begin
            if (exec && opc_r == OPC_SLEEP) begin
                sleep_r <= 1'b1;                                            // R02
            end else if (cs_rise && opc_r == OPC_WAKE_ID && (in_arg || st_r == ST_IDOUT)) begin
                sleep_r <= 1'b0;                                            // R02
            end
            if (exec && opc_r == OPC_OTP_ENTER) begin
                otp_mode_o <= 1'b1;                                         // R04
            end else if (exec && opc_r == OPC_OTP_EXIT) begin
                otp_mode_o <= 1'b0;                                         // R05
            end
        end
    end
    logic indiv_q_r;
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            all_locked_o <= 1'b0;
            indiv_q_r    <= 1'b0;
        end else if (ce_i) begin
            indiv_q_r <= indiv_mode_i;
            if (indiv_mode_i && !indiv_q_r) begin
                all_locked_o <= 1'b1;                                       // R07
            end else if (gang_x && wel_r) begin
                all_locked_o <= (opc_r == OPC_GANG_LOCK);                   // R06
            end
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            req_valid_o <= 1'b0;
            req_o       <= '0;
            so_o        <= 1'b0;
            so_oe_o     <= 1'b0;
            status_o    <= '0;
        end else if (ce_i) begin
            req_valid_o <= grant_x;                                         // R01 R14
            if (grant_x) begin
                // Status write data is the received byte unmasked, latch and busy bit positions included
                req_o <= '{op: dec.op, addr: addr_r, data: sh_r};           // R16
            end
            so_o     <= id_sh_r[7];
            so_oe_o  <= cs_act && st_r == ST_IDOUT;
            status_o <= {sr_hi_i, wel_r, busy_i};                           // R16
        end
    end
    assign write_enable_latch_o = wel_r;
    assign deep_sleep_o         = sleep_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_r);
    property p_set_latch;
        (ce_i && set_x) |=> wel_r;
    endproperty
    a_set_latch: assert property (p_set_latch) else $error("latch not set"); // R10
    property p_clr_latch;
        (ce_i && clr_x && !set_x) |=> !write_enable_latch_o;
    endproperty
    a_clr_latch: assert property (p_clr_latch) else $error("latch not cleared"); // R11
    property p_done_clr;
        (ce_i && op_done_i && !set_x) |=> !wel_r ##1 (status_o[1] == wel_r);
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("completion kept latch"); // R12
    property p_refuse;
        $rose(req_valid_o) |-> $past(wel_r) && !$past(protect_hit_i && !lock_op
            && dec.op != FCD_OP_STATUS_WR);
    endproperty
    a_refuse: assert property (p_refuse) else $error("request without latch"); // R14
    property p_protect;
        (ce_i && prot_x && !set_x) |=> !req_valid_o && !wel_r;
    endproperty
    a_protect: assert property (p_protect) else $error("protected target run"); // R15
    property p_lock_clr;
        (ce_i && (gang_x || (mod_x && lock_op))) |=> !wel_r;
    endproperty
    a_lock_clr: assert property (p_lock_clr) else $error("lock kept latch"); // R13
    property p_sleep;
        (ce_i && exec && opc_r == OPC_SLEEP) |=> deep_sleep_o;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered"); // R02
    property p_otp;
        (ce_i && exec && opc_r == OPC_OTP_ENTER) |=> otp_mode_o;
    endproperty
    a_otp: assert property (p_otp) else $error("otp mode not entered"); // R04
    property p_gang;
        (ce_i && gang_x && wel_r && !(indiv_mode_i && !indiv_q_r))
        |=> all_locked_o == $past(opc_r == OPC_GANG_LOCK);
    endproperty
    a_gang: assert property (p_gang) else $error("gang lock state wrong"); // R06
    property p_ignore;
        (ce_i && st_r == ST_IGNORE && !op_done_i) |=> $stable(wel_r) && !req_valid_o;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored opcode acted"); // R17

endmodule : fcd_decoder

/* File: fcd_host.sv */
// Host controller model driving the serial link of the command decoder
module fcd_host (
    input  wire logic mclk_i,
    input  wire logic so_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      si_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx_r;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o   = 1'b0;
        rx_r   = 8'h00;
    end
    // ****************************************
    // One frame, MSB first, rd bytes read back
    // ****************************************
    task automatic frame(input logic [63:0] b, input int n, input int rd);
        int i;
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            #62.5 si_o <= b[i];
            sclk_o <= 1'b0;
            #62.5 sclk_o <= 1'b1;
        end
        for (i = 0; i < rd * 8; i++) begin
            #62.5 sclk_o <= 1'b0;
            #62.5 rx_r <= {rx_r[6:0], so_i};
            sclk_o <= 1'b1;
        end
        #62.5 sclk_o <= 1'b0;
        #62.5 cs_n_o <= 1'b1;
        si_o <= ~si_o;  // Released line must not keep its last value
        repeat (12) @(posedge mclk_i);
    endtask : frame
endmodule : fcd_host

/* File: flash_cmd_decode_write_latch_tb.sv */
// Self-checking bench for the flash command decoder
module flash_cmd_decode_write_latch_tb;
    import fcd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic            mclk_i, rst_n_i, busy_i, op_done_i, prot, indiv, ce;
    logic [5:0]      sr_hi_i;
    logic            cs_n, sclk, si, so_o, so_oe_o, write_enable_latch, sleep, otp, locked, req_valid_o;
    fcd_req_t        req_o, last_req;
    logic [SR_W-1:0] status_o;
    logic [23:0]     a;
    logic [7:0]      d;
    int              err_total, checks_done, req_cnt, exp_cnt, oe_cnt, seed, i;
    localparam logic [7:0] OPL [9] = '{OPC_HALF_BLK_ERASE, OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B,
        OPC_SECT_ERASE, OPC_BLK_ERASE, OPC_PAGE_PROG, OPC_QUAD_PROG, OPC_CONT_PROG, OPC_STATUS_WR};
    localparam int NL [9] = '{32, 8, 8, 32, 32, 40, 40, 40, 16};
    localparam fcd_op_t OPS [9] = '{FCD_OP_HALF_BLK_ERASE, FCD_OP_CHIP_ERASE, FCD_OP_CHIP_ERASE,
        FCD_OP_SECT_ERASE, FCD_OP_BLK_ERASE, FCD_OP_PAGE_PROG, FCD_OP_QUAD_PROG,
        FCD_OP_CONT_PROG, FCD_OP_STATUS_WR};

    fcd_decoder uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .cs_n_i(cs_n),
        .sclk_i(sclk), .si_i(si), .busy_i(busy_i), .op_done_i(op_done_i),
        .protect_hit_i(prot), .indiv_mode_i(indiv), .sr_hi_i(sr_hi_i), .so_o(so_o),
        .so_oe_o(so_oe_o), .write_enable_latch_o(write_enable_latch), .deep_sleep_o(sleep),
        .otp_mode_o(otp), .all_locked_o(locked), .req_valid_o(req_valid_o),
        .req_o(req_o), .status_o(status_o));
    fcd_host host (.mclk_i(mclk_i), .so_i(so_o), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // Request pulse lasts one cycle, so it is caught here
    always @(posedge mclk_i) begin
        if (req_valid_o === 1'b1) begin
            req_cnt++;
            last_req = req_o;
        end
        if (so_oe_o === 1'b1) oe_cnt++;
    end
    // ****************************************
    // Expectation and check helpers
    // ****************************************
    function automatic logic [63:0] mk(input logic [7:0] o, input int n,
                                       input logic [23:0] ad, input logic [7:0] dt);
        case (n)
            16: mk = {48'h0, o, dt};
            32: mk = {32'h0, o, ad};
            40: mk = {24'h0, o, ad, dt};
            default: mk = {56'h0, o};
        endcase
    endfunction : mk
    function automatic logic [7:0] exp_status(input logic [5:0] h, input logic l, input logic b);
        exp_status = {h, l, b};
    endfunction : exp_status
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic cmd(input logic [7:0] o);
        host.frame({56'h0, o}, 8, 0);
    endtask : cmd
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #500us;
        err_total++;
        complete_run();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 35;
        {err_total, checks_done, req_cnt, exp_cnt, oe_cnt} = '0;
        {rst_n_i, busy_i, op_done_i, prot, indiv} = '0;
        ce = 1'b1;
        sr_hi_i = 6'h00;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        check("latch_powerup", 0, write_enable_latch);
        cmd(OPC_SET_WL);
        check("latch_set", 1, write_enable_latch);
        cmd(OPC_CLR_WL);
        check("latch_clr", 0, write_enable_latch);
        ce <= 1'b0;
        cmd(OPC_SET_WL);
        check("ce_frozen", 0, write_enable_latch);
        ce <= 1'b1;
        for (i = 0; i < 9; i++) begin
            a = 24'($random(seed));
            d = 8'($random(seed));
            sr_hi_i <= 6'($random(seed));
            cmd(OPC_SET_WL);
            host.frame(mk(OPL[i], NL[i], a, d), NL[i], 0);
            exp_cnt++;
            check("req_count", exp_cnt, req_cnt);
            check("req_op", OPS[i], last_req.op);
            if (NL[i] >= 32) check("req_addr", a, last_req.addr);
            if (NL[i] == 16) check("req_data", d, last_req.data);
            check("status_latch", exp_status(sr_hi_i, 1'b1, 1'b0), status_o);
            op_done_i <= 1'b1;
            @(posedge mclk_i);
            op_done_i <= 1'b0;
            repeat (3) @(posedge mclk_i);
            check("latch_done", 0, write_enable_latch);
        end
        host.frame(mk(OPC_HALF_BLK_ERASE, 32, a, d), 32, 0);
        check("refused_no_latch", exp_cnt, req_cnt);
        cmd(OPC_SET_WL);
        prot <= 1'b1;
        host.frame(mk(OPC_SECT_ERASE, 32, a, d), 32, 0);
        prot <= 1'b0;
        check("protected_req", exp_cnt, req_cnt);
        check("protected_latch", 0, write_enable_latch);
        cmd(OPC_SET_WL);
        host.frame({48'h0, 16'hff00 | 16'(d)}, 16, 0);
        host.frame(mk(OPC_HALF_BLK_ERASE, 32, a, d) >> 1, 31, 0);
        check("unknown_latch", 1, write_enable_latch);
        check("short_frame_req", exp_cnt, req_cnt);
        busy_i <= 1'b1;
        cmd(OPC_CLR_WL);
        check("busy_status", exp_status(sr_hi_i, 1'b1, 1'b1), status_o);
        busy_i <= 1'b0;
        cmd(OPC_OTP_ENTER);
        check("otp_enter", 1, otp);
        cmd(OPC_OTP_EXIT);
        check("otp_exit", 0, otp);
        cmd(OPC_GANG_LOCK);
        check("gang_lock", 1, locked);
        check("gang_lock_latch", 0, write_enable_latch);
        cmd(OPC_GANG_UNLOCK);
        check("gang_unlock_refused", 1, locked);
        cmd(OPC_SET_WL);
        cmd(OPC_GANG_UNLOCK);
        check("gang_unlock", 0, locked);
        check("gang_unlock_latch", 0, write_enable_latch);
        for (i = 0; i < 2; i++) begin
            cmd(OPC_SET_WL);
            host.frame(mk(i ? OPC_ONE_UNLOCK : OPC_ONE_LOCK, 32, a, d), 32, 0);
            exp_cnt++;
            check("one_lock_op", i ? FCD_OP_ONE_UNLOCK : FCD_OP_ONE_LOCK, last_req.op);
            check("one_lock_latch", 0, write_enable_latch);
        end
        indiv <= 1'b1;
        repeat (4) @(posedge mclk_i);
        check("indiv_locked", 1, locked);
        cmd(OPC_SLEEP);
        check("sleep_enter", 1, sleep);
        cmd(OPC_SET_WL);
        check("sleep_ignores", 0, write_enable_latch);
        cmd(OPC_WAKE_ID);
        check("sleep_exit", 0, sleep);
        cmd(OPC_SLEEP);
        host.frame({32'h0, OPC_WAKE_ID, 24'h000000}, 32, 1);
        check("id_byte", ID_DEFAULT, host.rx_r);
        check("id_wake", 0, sleep);
        check("id_release", 0, so_oe_o);
        check("id_drive", 1, oe_cnt > 0);
        check("req_total", exp_cnt, req_cnt);
        complete_run();
    end
endmodule : flash_cmd_decode_write_latch_tb
